// >>> rtl/smbus_master.sv
// SMBus master engine: PEC, timeouts, quick and alternative command, lock, arbitration
`timescale 1ns/1ns
`default_nettype none
module smbus_master #(
  parameter logic [15:0] DIV_RESET = i2c_pkg::DIV_RST
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic OWN_ACK_INHIBIT
);
  typedef struct packed {
    i2c_pkg::state_t st;
    i2c_pkg::kind_t kind;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rdir, seg2, quick, lastrx, pecdone, ackn, go, stop_req;
    logic master_enable_ctl, acm, smbus_enable_ctl, pec_enable_ctl;
    logic [6:0] taddr;
    logic read_direction_bit;
    logic [7:0] len, l1, l2;
    logic d1, d2, p1, p2;
    logic [15:0] tlm, tls, div, dcnt, tcnt;
    logic [7:0] tx_holding_reg, rhr;
    logic thr_full, rxrdy, transmit_complete_flag, nack, arbitration_lost_flag, timeout_flag, pec_error_flag, lock, busy;
    logic [1:0] scl_s, sda_s;
    logic scl_p, sda_p, scl_drv, sda_drv;
    logic [31:0] rdata;
  } st_t;

  st_t r_reg;
  st_t r_next;
  logic scl;
  logic sda;
  logic tick;
  logic tmo;
  logic arb_lost;
  logic sample_evt;
  logic is_tx;
  logic pecnow;
  logic crc_clr;
  logic crc_en;
  crc_if crc_bus();

  pec_crc8 u_crc (
    .CLK(CLK),
    .RSTN(RSTN),
    .p(crc_bus)
  );

  // Checksum register fed from the bit sampler
  assign crc_bus.clr = crc_clr;
  assign crc_bus.en = crc_en;
  assign crc_bus.d = sda;

  // Only the second synchroniser stage is used by logic
  assign scl = r_reg.scl_s[1];
  assign sda = r_reg.sda_s[1];
  assign tick = (r_reg.dcnt == 16'h0000);
  assign is_tx = (r_reg.kind == i2c_pkg::K_ADDR) || (r_reg.kind == i2c_pkg::K_TX)
      || (r_reg.kind == i2c_pkg::K_PECTX);
  assign sample_evt = (r_reg.st == i2c_pkg::S_BITS) && tick && (r_reg.ph == 2'h2);
  // A released one that reads back as zero means another master won
  assign arb_lost = sample_evt && (r_reg.bitn < 4'h8) && is_tx && r_reg.sh[7] && !sda;
  // Checksum only on the final segment of a frame
  assign pecnow = !r_reg.seg2 && (r_reg.acm ? ((r_reg.l2 != 8'h00) ? r_reg.p2 : r_reg.p1)
      : r_reg.pec_enable_ctl);
  // Low-time counter covers the frame up to its stop, including stretching by a slave
  assign tmo = r_reg.smbus_enable_ctl && (r_reg.st != i2c_pkg::S_IDLE) && (r_reg.st != i2c_pkg::S_WAITF)
      && (r_reg.st != i2c_pkg::S_STOP) && (((r_reg.tlm != 16'h0000) && (r_reg.tcnt >= r_reg.tlm))
      || ((r_reg.tls != 16'h0000) && (r_reg.tcnt >= r_reg.tls)));

  // Next-state logic: bus access first except the holding write, then the engine so its flag sets win
  always_comb begin
    logic endseg;
    logic tostop;
    logic [31:0] stat;
    endseg = 1'b0;
    tostop = 1'b0;
    stat = '0;
    r_next = r_reg;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    r_next.rdata = '0;
    r_next.scl_s = {r_reg.scl_s[0], SCL_IN};
    r_next.sda_s = {r_reg.sda_s[0], SDA_IN};
    r_next.scl_p = scl;
    r_next.sda_p = sda;
    r_next.dcnt = tick ? r_reg.div - 16'h0001 : r_reg.dcnt - 16'h0001;
    // Bus state kept internally only, never in status
    if (scl && r_reg.scl_p && r_reg.sda_p && !sda) begin
      r_next.busy = 1'b1;
    end
    if (scl && r_reg.scl_p && !r_reg.sda_p && sda) begin
      r_next.busy = 1'b0;
    end
    // Control and configuration writes
    if (WR) begin
      unique case (ADDR)
        i2c_pkg::OFF_CTRL: begin
          if (WDATA[i2c_pkg::CB_START]) r_next.go = 1'b1;
          if (WDATA[i2c_pkg::CB_STOP]) r_next.stop_req = 1'b1;
          if (WDATA[i2c_pkg::CB_MASTER_ENABLE_CTL]) r_next.master_enable_ctl = 1'b1;
          if (WDATA[i2c_pkg::CB_MASTER_DISABLE_CTL]) r_next.master_enable_ctl = 1'b0;
          if (WDATA[i2c_pkg::CB_QUICK]) begin
            r_next.go = 1'b1;
            r_next.quick = 1'b1;
          end
          if (WDATA[i2c_pkg::CB_PEC_ENABLE_CTL]) r_next.pec_enable_ctl = 1'b1;
          if (WDATA[i2c_pkg::CB_LOCK_CLEAR_CTL]) r_next.lock = 1'b0;
          if (WDATA[i2c_pkg::CB_TX_HOLDING_FLUSH_CTL]) begin
            r_next.thr_full = 1'b0;
            r_next.transmit_complete_flag = 1'b1;
          end
          if (WDATA[i2c_pkg::CB_ALT_COMMAND_ENABLE]) r_next.acm = 1'b1;
          if (WDATA[i2c_pkg::CB_ACMDIS]) r_next.acm = 1'b0;
          if (WDATA[i2c_pkg::CB_SMBUS_ENABLE_CTL]) r_next.smbus_enable_ctl = 1'b1;
          if (WDATA[i2c_pkg::CB_SMBDIS]) r_next.smbus_enable_ctl = 1'b0;
        end
        i2c_pkg::OFF_MODE: begin
          r_next.taddr = WDATA[6:0];
          r_next.read_direction_bit = WDATA[i2c_pkg::MODE_READ];
        end
        i2c_pkg::OFF_ALT: begin
          r_next.l1 = WDATA[7:0];
          r_next.d1 = WDATA[i2c_pkg::ALT_DIR];
          r_next.p1 = WDATA[i2c_pkg::ALT_PEC];
          r_next.l2 = WDATA[i2c_pkg::ALT_NLEN +: 8];
          r_next.d2 = WDATA[i2c_pkg::ALT_SECOND_DIRECTION];
          r_next.p2 = WDATA[i2c_pkg::ALT_NEXT_TRANSFER_PEC_BIT];
        end
        i2c_pkg::OFF_TMO: begin
          r_next.tlm = WDATA[15:0];
          r_next.tls = WDATA[31:16];
        end
        i2c_pkg::OFF_DIV: r_next.div = WDATA[15:0];
        default: ;
      endcase
    end
    // Status word; reading it clears the error flags
    stat[i2c_pkg::SB_TRANSMIT_COMPLETE_FLAG] = r_reg.transmit_complete_flag;
    stat[i2c_pkg::SB_RXRDY] = r_reg.rxrdy;
    stat[i2c_pkg::SB_TX_HOLDING_EMPTY_FLAG] = !r_reg.thr_full;
    stat[i2c_pkg::SB_NACK] = r_reg.nack;
    stat[i2c_pkg::SB_ARBITRATION_LOST_FLAG] = r_reg.arbitration_lost_flag;
    stat[i2c_pkg::SB_TIMEOUT_FLAG] = r_reg.timeout_flag;
    stat[i2c_pkg::SB_PEC_ERROR_FLAG] = r_reg.pec_error_flag;
    stat[i2c_pkg::SB_LOCK] = r_reg.lock;
    if (RD) begin
      unique case (ADDR)
        i2c_pkg::OFF_STAT: begin
          r_next.rdata = stat;
          r_next.nack = 1'b0;
          r_next.arbitration_lost_flag = 1'b0;
          r_next.timeout_flag = 1'b0;
          r_next.pec_error_flag = 1'b0;
        end
        i2c_pkg::OFF_RHR: begin
          r_next.rdata = {24'h00_0000, r_reg.rhr};
          r_next.rxrdy = 1'b0;
        end
        i2c_pkg::OFF_MODE: r_next.rdata = 32'({r_reg.read_direction_bit, 5'h00, r_reg.taddr});
        i2c_pkg::OFF_ALT: r_next.rdata = {6'h00, r_reg.p2, r_reg.d2, r_reg.l2, 6'h00, r_reg.p1,
            r_reg.d1, r_reg.l1};
        i2c_pkg::OFF_TMO: r_next.rdata = {r_reg.tls, r_reg.tlm};
        i2c_pkg::OFF_DIV: r_next.rdata = {16'h0000, r_reg.div};
        default: r_next.rdata = '0;
      endcase
    end
    // Low-time counter in divider ticks, cleared whenever the clock line is high
    if ((r_reg.st == i2c_pkg::S_IDLE) || (r_reg.st == i2c_pkg::S_WAITF) || scl) begin
      r_next.tcnt = '0;
    end else if (tick && (r_reg.tcnt != 16'hFFFF)) begin
      r_next.tcnt = r_reg.tcnt + 16'h0001;
    end
    // Frame sequencer
    unique case (r_reg.st)
      i2c_pkg::S_IDLE: begin
        // Pending nack or timeout flags, or lock, keep new frames out
        if (r_reg.go && r_reg.master_enable_ctl && !r_reg.lock && !r_reg.nack && !r_reg.timeout_flag) begin
          r_next.st = i2c_pkg::S_WAITF;
          r_next.go = 1'b0;
          crc_clr = 1'b1;
          r_next.rdir = (r_reg.acm && !r_reg.quick) ? r_reg.d1 : r_reg.read_direction_bit;
          r_next.len = r_reg.l1;
          r_next.seg2 = r_reg.acm && !r_reg.quick && (r_reg.l2 != 8'h00);
          r_next.pecdone = 1'b0;
          r_next.lastrx = 1'b0;
          r_next.transmit_complete_flag = 1'b0;
        end
      end
      i2c_pkg::S_WAITF: begin
        if (!r_reg.busy && tick) begin
          r_next.st = i2c_pkg::S_START;
          r_next.ph = 2'h0;
        end
      end
      i2c_pkg::S_START: begin
        // Same sequence serves a first start and a repeated start
        if (tick) begin
          unique case (r_reg.ph)
            2'h0: begin
              r_next.sda_drv = 1'b0;
              r_next.ph = 2'h1;
            end
            2'h1: begin
              r_next.scl_drv = 1'b0;
              if (scl) r_next.ph = 2'h2;
            end
            2'h2: begin
              r_next.sda_drv = 1'b1;
              r_next.ph = 2'h3;
            end
            default: begin
              r_next.scl_drv = 1'b1;
              r_next.st = i2c_pkg::S_BITS;
              r_next.kind = i2c_pkg::K_ADDR;
              r_next.bitn = 4'h0;
              r_next.ph = 2'h0;
              r_next.sh = {r_reg.taddr, r_reg.rdir};
            end
          endcase
        end
      end
      i2c_pkg::S_BITS: begin
        if (r_reg.bitn == 4'h9) begin
          // Byte boundary: the clock stays low while the next step is chosen
          if (is_tx && r_reg.ackn) begin
            r_next.nack = 1'b1;
            if (r_reg.acm) r_next.lock = 1'b1;
            tostop = 1'b1;
          end else if ((r_reg.kind == i2c_pkg::K_ADDR) && r_reg.quick) begin
            tostop = 1'b1;
          end else if ((r_reg.kind == i2c_pkg::K_PECTX) || (r_reg.kind == i2c_pkg::K_PECRX)) begin
            endseg = 1'b1;
          end else if (!r_reg.rdir) begin
            if (r_reg.acm ? (r_reg.len != 8'h00) : r_reg.thr_full) begin
              // Without holding data the line is stretched until software writes
              if (r_reg.thr_full) begin
                r_next.sh = r_reg.tx_holding_reg;
                r_next.thr_full = 1'b0;
                r_next.kind = i2c_pkg::K_TX;
                r_next.len = r_reg.len - 8'h01;
                r_next.bitn = 4'h0;
                r_next.ph = 2'h0;
              end
            end else if (r_reg.acm || r_reg.stop_req) begin
              endseg = 1'b1;
            end
          end else if ((r_reg.kind == i2c_pkg::K_ADDR) ? (!r_reg.acm || (r_reg.len != 8'h00))
              : !r_reg.lastrx) begin
            r_next.kind = i2c_pkg::K_RX;
            r_next.len = r_reg.len - 8'h01;
            r_next.bitn = 4'h0;
            r_next.ph = 2'h0;
          end else begin
            endseg = 1'b1;
          end
        end else if (tick) begin
          unique case (r_reg.ph)
            2'h0: begin
              r_next.ph = 2'h1;
              if (r_reg.bitn < 4'h8) begin
                r_next.sda_drv = is_tx && !r_reg.sh[7];
              end else if (r_reg.kind == i2c_pkg::K_RX) begin
                // Ack all but a final byte that no checksum follows
                r_next.sda_drv = !((r_reg.acm ? (r_reg.len == 8'h00) : r_reg.stop_req) && !pecnow);
              end else begin
                r_next.sda_drv = 1'b0;
              end
            end
            2'h1: begin
              r_next.scl_drv = 1'b0;
              if (scl) r_next.ph = 2'h2;
            end
            2'h2: begin
              r_next.ph = 2'h3;
              if (r_reg.bitn < 4'h8) begin
                crc_en = 1'b1;
                r_next.sh = {r_reg.sh[6:0], sda};
              end else begin
                r_next.ackn = sda;
                r_next.lastrx = r_reg.acm ? (r_reg.len == 8'h00) : r_reg.stop_req;
                if (r_reg.kind == i2c_pkg::K_RX) begin
                  r_next.rhr = r_reg.sh;
                  r_next.rxrdy = 1'b1;
                end
                // Feeding the check byte leaves zero when it matches
                if ((r_reg.kind == i2c_pkg::K_PECRX) && (crc_bus.crc != 8'h00)) begin
                  r_next.pec_error_flag = 1'b1;
                end
              end
            end
            default: begin
              r_next.scl_drv = 1'b1;
              r_next.ph = 2'h0;
              r_next.bitn = r_reg.bitn + 4'h1;
            end
          endcase
        end
      end
      i2c_pkg::S_STOP: begin
        if (tick) begin
          unique case (r_reg.ph)
            2'h0: begin
              r_next.sda_drv = 1'b1;
              r_next.ph = 2'h1;
            end
            2'h1: begin
              r_next.scl_drv = 1'b0;
              if (scl) r_next.ph = 2'h2;
            end
            2'h2: begin
              r_next.sda_drv = 1'b0;
              r_next.ph = 2'h3;
            end
            default: begin
              r_next.st = i2c_pkg::S_IDLE;
              r_next.ph = 2'h0;
              r_next.transmit_complete_flag = 1'b1;
              r_next.stop_req = 1'b0;
              r_next.quick = 1'b0;
              r_next.pec_enable_ctl = 1'b0;
            end
          endcase
        end
      end
      default: r_next.st = i2c_pkg::S_IDLE;
    endcase
    // End of a segment: checksum, repeated start or stop
    if (endseg) begin
      if (pecnow && !r_reg.pecdone) begin
        r_next.pecdone = 1'b1;
        r_next.bitn = 4'h0;
        r_next.ph = 2'h0;
        r_next.kind = r_reg.rdir ? i2c_pkg::K_PECRX : i2c_pkg::K_PECTX;
        r_next.sh = r_reg.rdir ? 8'h00 : crc_bus.crc;
      end else if (r_reg.seg2) begin
        r_next.seg2 = 1'b0;
        r_next.rdir = r_reg.d2;
        r_next.len = r_reg.l2;
        r_next.lastrx = 1'b0;
        r_next.st = i2c_pkg::S_START;
        r_next.ph = 2'h0;
      end else begin
        tostop = 1'b1;
      end
    end
    // Timeout overrides whatever the sequencer chose
    if (tmo) begin
      r_next.timeout_flag = 1'b1;
      if (r_reg.acm) r_next.lock = 1'b1;
      tostop = 1'b1;
    end
    if (tostop) begin
      r_next.st = i2c_pkg::S_STOP;
      r_next.ph = 2'h0;
      r_next.scl_drv = 1'b1;
    end
    // Lost arbitration: let go of both lines and drop the request
    if (arb_lost) begin
      r_next.arbitration_lost_flag = 1'b1;
      r_next.st = i2c_pkg::S_IDLE;
      r_next.scl_drv = 1'b0;
      r_next.sda_drv = 1'b0;
      r_next.go = 1'b0;
      r_next.quick = 1'b0;
      r_next.stop_req = 1'b0;
      r_next.pec_enable_ctl = 1'b0;
    end
    // Holding write last so new data is never lost to a same-cycle load
    if (WR && (ADDR == i2c_pkg::OFF_THR)) begin
      r_next.tx_holding_reg = WDATA[7:0];
      r_next.thr_full = 1'b1;
      if (r_reg.acm && !r_reg.d1) r_next.go = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg <= '{st: i2c_pkg::S_IDLE, kind: i2c_pkg::K_ADDR, div: DIV_RESET, scl_s: 2'h3,
          sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Open-drain pins only ever pull low
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = r_reg.scl_drv;
  assign SDA_OE = r_reg.sda_drv;
  assign RDATA = r_reg.rdata;
  assign OWN_ACK_INHIBIT = r_reg.arbitration_lost_flag;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence seq_flush_wr;
    WR && (ADDR == i2c_pkg::OFF_CTRL) && WDATA[i2c_pkg::CB_TX_HOLDING_FLUSH_CTL];
  endsequence
  sequence seq_stop_done;
    (r_reg.st == i2c_pkg::S_STOP) && (r_reg.ph == 2'h3) && tick;
  endsequence

  AST_PEC_ONE_FRAME: assert property (seq_stop_done |=> !r_reg.pec_enable_ctl && r_reg.transmit_complete_flag)
    else $error("PEC enable survived end of frame");
  // Checked against the polynomial step itself, not against the enable that drives it
  AST_CRC_EVERY_BIT: assert property (sample_evt && (r_reg.bitn < 4'h8) |=> crc_bus.crc
      == ({$past(crc_bus.crc[6:0]), 1'b0} ^ (($past(crc_bus.crc[7]) ^ $past(sda)) ? i2c_pkg::CRC_POLY : 8'h00)))
    else $error("Line bit not fed to checksum");
  AST_PEC_TX_VALUE: assert property ($rose(r_reg.kind == i2c_pkg::K_PECTX)
      |-> r_reg.sh == $past(crc_bus.crc))
    else $error("Sent check byte differs from checksum");
  AST_PEC_MISMATCH: assert property (sample_evt && (r_reg.bitn == 4'h8)
      && (r_reg.kind == i2c_pkg::K_PECRX) && (crc_bus.crc != 8'h00) |=> r_reg.pec_error_flag)
    else $error("Check byte mismatch not flagged");
  AST_PEC_RX_NACK: assert property ((r_reg.st == i2c_pkg::S_BITS) && (r_reg.bitn == 4'h8)
      && (r_reg.kind == i2c_pkg::K_PECRX) |-> !r_reg.sda_drv)
    else $error("Check byte acknowledged");
  AST_TIMEOUT_STOP: assert property (tmo |=> r_reg.timeout_flag && (r_reg.st == i2c_pkg::S_STOP)
      || r_reg.arbitration_lost_flag)
    else $error("Timeout did not stop the frame");
  AST_ALT_LOCK: assert property (tmo && r_reg.acm |=> r_reg.lock)
    else $error("Alternative mode timeout did not lock");
  AST_LOCK_BLOCKS: assert property ((r_reg.st == i2c_pkg::S_IDLE) && r_reg.lock
      |=> r_reg.st != i2c_pkg::S_WAITF)
    else $error("Frame began while locked");
  AST_FLUSH: assert property (seq_flush_wr |=> !r_reg.thr_full && r_reg.transmit_complete_flag)
    else $error("Holding flush did not take effect");
  AST_ARB_RELEASE: assert property (arb_lost |=> r_reg.arbitration_lost_flag && !SDA_OE && !SCL_OE
      ##1 r_reg.st != i2c_pkg::S_START)
    else $error("Bus not released after arbitration loss");
  AST_WAIT_FREE: assert property ((r_reg.st == i2c_pkg::S_WAITF) && r_reg.busy
      |=> (r_reg.st == i2c_pkg::S_WAITF) && !SDA_OE)
    else $error("Start driven on a busy bus");
  AST_NO_OWN_ACK: assert property ($rose(r_reg.arbitration_lost_flag) |-> OWN_ACK_INHIBIT)
    else $error("Own address ack not inhibited");
endmodule : smbus_master
`default_nettype wire

// >>> rtl/i2c_pkg.sv
// Shared constants and types for the SMBus master engine
package i2c_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_ALT = 8'h08;
  localparam logic [7:0] OFF_TMO = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_THR = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_DIV = 8'h1C;
  // Control strobe bit positions
  localparam int CB_START = 0;
  localparam int CB_STOP = 1;
  localparam int CB_MASTER_ENABLE_CTL = 2;
  localparam int CB_MASTER_DISABLE_CTL = 3;
  localparam int CB_QUICK = 4;
  localparam int CB_PEC_ENABLE_CTL = 5;
  localparam int CB_LOCK_CLEAR_CTL = 6;
  localparam int CB_TX_HOLDING_FLUSH_CTL = 7;
  localparam int CB_ALT_COMMAND_ENABLE = 8;
  localparam int CB_ACMDIS = 9;
  localparam int CB_SMBUS_ENABLE_CTL = 10;
  localparam int CB_SMBDIS = 11;
  // Status bit positions
  localparam int SB_TRANSMIT_COMPLETE_FLAG = 0;
  localparam int SB_RXRDY = 1;
  localparam int SB_TX_HOLDING_EMPTY_FLAG = 2;
  localparam int SB_NACK = 3;
  localparam int SB_ARBITRATION_LOST_FLAG = 4;
  localparam int SB_TIMEOUT_FLAG = 5;
  localparam int SB_PEC_ERROR_FLAG = 6;
  localparam int SB_LOCK = 7;
  // Mode and alternative command fields
  localparam int MODE_READ = 12;
  localparam int ALT_DIR = 8;
  localparam int ALT_PEC = 9;
  localparam int ALT_NLEN = 16;
  localparam int ALT_SECOND_DIRECTION = 24;
  localparam int ALT_NEXT_TRANSFER_PEC_BIT = 25;
  // CRC-8, x^8+x^2+x+1, zero seed
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Bit timing: four phases per bit, five divider ticks as the clock-high wait takes two
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 160;
  localparam logic [15:0] DIV_RST = 16'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_WAITF = 5'h02, S_START = 5'h04, S_BITS = 5'h08, S_STOP = 5'h10
  } state_t;
  typedef enum logic [2:0] {
    K_ADDR = 3'h0, K_TX = 3'h1, K_RX = 3'h2, K_PECTX = 3'h3, K_PECRX = 3'h4
  } kind_t;
endpackage : i2c_pkg

// >>> rtl/crc_if.sv
// Connection between the bit engine and the checksum register
`timescale 1ns/1ns
`default_nettype none
interface crc_if;
  logic clr;
  logic en;
  logic d;
  logic [7:0] crc;
  modport user (output clr, output en, output d, input crc);
  modport engine (input clr, input en, input d, output crc);
endinterface : crc_if
`default_nettype wire

// >>> rtl/pec_crc8.sv
// Bit-serial packet error check register
`timescale 1ns/1ns
`default_nettype none
module pec_crc8 (
  input wire logic CLK,
  input wire logic RSTN,
  crc_if.engine p
);
  typedef struct packed {
    logic [7:0] crc;
  } crc_st_t;
  crc_st_t c_reg;
  crc_st_t c_next;

  // One shift per line bit, MSB first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic d);
    logic fb;
    fb = c[7] ^ d;
    crc_step = {c[6:0], 1'b0} ^ (fb ? i2c_pkg::CRC_POLY : 8'h00);
  endfunction : crc_step

  // Clear only at frame start so a repeated start keeps the sum
  always_comb begin
    c_next = c_reg;
    if (p.clr) begin
      c_next.crc = i2c_pkg::CRC_INIT;
    end else if (p.en) begin
      c_next.crc = crc_step(c_reg.crc, p.d);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign p.crc = c_reg.crc;
endmodule : pec_crc8
`default_nettype wire

// >>> bench/smbus_slave_model.sv
// Behavioural SMBus slave: acks or nacks each byte and logs what it hears
`timescale 1ns/1ns
`default_nettype none
module smbus_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_all,
  output logic sda_oe = 0,
  output int n_bytes = 0,
  output int n_starts = 0,
  output logic [31:0] log_q
);
  int bitc = 0;
  logic [7:0] sh;
  // Start rearms the count; the clock fall that ends a start is not a bit
  always @(negedge sda) if (scl) begin
    bitc = -1;
    n_bytes = 0;
    n_starts++;
  end
  always @(posedge scl) if (bitc >= 0 && bitc < 8) sh = {sh[6:0], sda};
  // Never checks the checksum in time, so it acks unless told to refuse
  always @(negedge scl) begin
    bitc++;
    if (bitc == 8) begin
      log_q = {log_q[23:0], sh};
      n_bytes++;
      sda_oe = ~nack_all;
    end else if (bitc == 9) begin
      sda_oe = 0;
      bitc = 0;
    end
  end
endmodule : smbus_slave_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the SMBus master engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 0;
  logic rd = 0;
  logic nack_all = 0;
  logic other = 0;
  logic [31:0] rdata, log_q, s;
  logic scl_oe, sda_oe, s_oe, inh;
  // Open-drain lines with pull-ups
  wire logic scl = ~scl_oe;
  wire logic sda = ~(sda_oe | s_oe | other);
  int n_fail = 0;
  int n_compared = 0;
  int n_bytes, n_starts, st0;
  logic [6:0] a;
  logic [7:0] d;
  smbus_master i_smbus_master (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .OWN_ACK_INHIBIT(inh));
  smbus_slave_model i_smbus_slave_model (.scl(scl), .sda(sda), .nack_all(nack_all), .sda_oe(s_oe),
    .n_bytes(n_bytes), .n_starts(n_starts), .log_q(log_q));
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic [7:0] ad, input logic [31:0] v, input logic w, output logic [31:0] q);
    @(posedge clk);
    addr <= ad;
    wdata <= v;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 q = rdata;
  endtask : acc
  // Expected checksum, worked bit by bit, most significant first
  function automatic logic [7:0] crc8(input logic [7:0] c0, input logic [15:0] v);
    logic [7:0] c;
    c = c0;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  // Polls status until transmit complete; reads clear flags, so they are gathered
  task automatic frame(output logic [31:0] f);
    int i;
    f = 0;
    for (i = 0; i < 3000 && scl_oe !== 1'b1; i++) @(posedge clk);
    if (i >= 3000) chk(0, 1);
    for (i = 0; i < 3000 && f[0] !== 1'b1; i++) begin
      acc(8'h10, 0, 0, s);
      f |= s;
    end
    if (i >= 3000) chk(0, 1);
  endtask : frame
  // Alternative command single write: target, ALT, control, then holding write starts it
  task automatic alt_wr(input logic pec);
    acc(8'h04, 32'(a), 1, s);
    acc(8'h08, 32'h0000_0001 | 32'(pec) << 9, 1, s);
    acc(8'h00, 32'h0000_0504 | 32'(pec) << 5, 1, s);
    acc(8'h14, 32'(d), 1, s);
  endtask : alt_wr
  initial begin
    void'($urandom(32'h74b0));
    repeat (20) @(posedge clk);
    rstn <= 1;
    acc(8'h10, 0, 0, s);
    chk(s, 32'h0000_0004);
    for (int k = 0; k < 4; k++) begin
      a = 7'($urandom);
      d = (k == 3) ? 8'hFF : 8'($urandom);
      alt_wr(k[0]);
      frame(s);
      chk(s[3], 1'b0);
      chk(32'(n_bytes), 32'(2 + k[0]));
      chk(log_q[7:0], k[0] ? crc8(8'h00, {a, 1'b0, d}) : d);
    end
    acc(8'h08, 0, 1, s);
    acc(8'h04, 32'h0000_1000 | 32'(a), 1, s);
    acc(8'h00, 32'h0000_0010, 1, s);
    frame(s);
    chk(32'(n_bytes), 1);
    chk(log_q[7:0], {a, 1'b1});
    // Combined write then read; checksum asked only through the next-transfer bit
    a = 7'($urandom);
    d = 8'($urandom);
    st0 = n_starts;
    acc(8'h04, 32'(a), 1, s);
    acc(8'h08, 32'h0301_0001, 1, s);
    acc(8'h14, 32'(d), 1, s);
    frame(s);
    chk(32'(n_starts - st0), 32'h0000_0002);
    chk(32'(n_bytes), 32'h0000_0003);
    // Released line reads all ones, so the check byte matches only by chance
    chk(s[6], crc8(crc8(8'h00, {a, 1'b0, d}), {a, 1'b1, 8'hFF}) != 8'hFF);
    acc(8'h18, 0, 0, s);
    chk(s, 32'h0000_00FF);
    // Another master holds the data line from our first bit on: we lose, then queue behind it
    a = 7'($urandom) | 7'h40;
    acc(8'h04, 32'(a), 1, s);
    acc(8'h00, 32'h0000_0001, 1, s);
    @(posedge scl_oe);
    @(posedge clk);
    other <= 1'b1;
    repeat (200) @(posedge clk);
    chk(inh, 1'b1);
    chk({scl_oe, sda_oe}, 2'b00);
    acc(8'h14, 32'(d), 1, s);
    repeat (200) @(posedge clk);
    chk(sda_oe, 1'b0);
    other <= 1'b0;
    frame(s);
    chk(s & 32'h0000_0018, 32'h0000_0010);
    chk(inh, 1'b0);
    nack_all <= 1;
    alt_wr(1'b0);
    frame(s);
    chk(s & 32'h0000_0088, 32'h0000_0088);
    chk(32'(n_bytes), 1);
    nack_all <= 0;
    st0 = n_starts;
    acc(8'h14, 32'(d), 1, s);
    repeat (600) @(posedge clk);
    chk(32'(n_starts), 32'(st0));
    acc(8'h00, 32'h0000_0080, 1, s);
    acc(8'h10, 0, 0, s);
    chk(s & 32'h0000_0085, 32'h0000_0085);
    acc(8'h0C, 32'h0000_0010, 1, s);
    acc(8'h00, 32'h0000_0040, 1, s);
    acc(8'h10, 0, 0, s);
    chk(s[7], 1'b0);
    // The held request restarts after unlock but finds no data: the stretched clock must time out
    frame(s);
    chk(s & 32'h0000_00A1, 32'h0000_00A1);
    close_out();
  end
  // Whole run is near 13k cycles; this cuts a hang well beyond that
  initial begin
    #160000;
    n_fail++;
    close_out();
  end
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
endmodule : tb_top
`default_nettype wire
